// ---- design/port_selector.sv ----
module port_selector
    import port_select_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire ext_cmd_t         cmd,
    input  wire word_t            baseRegOne,
    input  wire word_t            baseRegTwo,
    input  wire word_t            processorWriteBus,
    input  wire port_words_t      portReadData,
    input  wire port_irq_t        portIrq,
    input  wire logic             loadSwitch,
    input  wire logic             loaderValid,
    input  wire word_t            loaderWord,
    output logic [PORT_CNT-1:0]   portSelect,
    output logic [GROUP_CNT-1:0]  groupSelect,
    output logic                  controlFormat,
    output word_t                 portWriteData,
    output logic                  portWriteStrobe,
    output logic                  portReadStrobe,
    output logic                  portDirOut,
    output logic [PORT_CNT-1:0]   statusAck,
    output word_t                 bRegData,
    output logic                  bRegValid,
    output logic [IDX_W-1:0]      statusLines,
    output logic                  statusLinesValid,
    output cu_req_t               cuReq,
    output logic                  mpmWrite,
    output logic [MPM_ADDR_W-1:0] mpmAddr,
    output logic [MPM_WORD_W-1:0] mpmData
);
    typedef struct packed {
        logic       selTwo;
        port_mask_t stPend;
        port_mask_t dtPend;
        logic       dirOut;
    } sel_state_t;

    sel_state_t       s_q;
    sel_state_t       s_d;
    word_t            devAddr;
    logic [IDX_W-1:0] idx;
    port_mask_t       idxMask;
    port_mask_t       pend;
    logic [IDX_W:0]   unaddrWin;
    logic [IDX_W:0]   asrWin;
    dev_op_t          op;
    port_mask_t       ackMask;

    // Base register choice and addressed port
    always_comb
    begin
        if (cmd.cmdTwo)
        begin
            devAddr = baseRegTwo;
        end
        else if (cmd.cmdOne)
        begin
            devAddr = baseRegOne;
        end
        else if (s_q.selTwo)
        begin
            devAddr = baseRegTwo;
        end
        else
        begin
            devAddr = baseRegOne;
        end
    end

    assign idx     = devAddr[IDX_W-1:0];
    assign idxMask = port_mask_t'(1) << idx;
    assign pend    = s_q.stPend | s_q.dtPend;

    // Priority among ports that are not addressed, and for the status request
    assign unaddrWin = pickHighest(pend & ~idxMask);
    assign asrWin    = pickHighest(pend);

    // Status request bypasses the read/write gating
    always_comb
    begin
        if (cmd.statusReq)
        begin
            op = OP_STATUS;
        end
        else if (cmd.memOp)
        begin
            op = OP_IDLE;
        end
        else if (cmd.read)
        begin
            op = OP_READ;
        end
        else if (cmd.write)
        begin
            op = OP_WRITE;
        end
        else
        begin
            op = OP_IDLE;
        end
    end

    // Port side strobes and data return
    always_comb
    begin
        portSelect      = '0;
        groupSelect     = '0;
        controlFormat   = 1'b0;
        portWriteData   = '0;
        portWriteStrobe = 1'b0;
        portReadStrobe  = 1'b0;
        bRegData        = '0;
        bRegValid       = 1'b0;
        ackMask         = '0;
        case (op)
            OP_READ:
            begin
                portSelect     = idxMask;
                groupSelect    = GROUP_CNT'(1) << idx[GROUP_BIT];
                controlFormat  = devAddr[FORMAT_BIT];
                portReadStrobe = 1'b1;
                bRegData       = portReadData[idx];
                bRegValid      = 1'b1;
            end
            OP_WRITE:
            begin
                portSelect      = idxMask;
                groupSelect     = GROUP_CNT'(1) << idx[GROUP_BIT];
                controlFormat   = devAddr[FORMAT_BIT];
                portWriteStrobe = 1'b1;
                portWriteData   = processorWriteBus;
            end
            OP_STATUS:
            begin
                if (asrWin[IDX_W])
                begin
                    portSelect     = port_mask_t'(1) << asrWin[IDX_W-1:0];
                    groupSelect    = GROUP_CNT'(1) << asrWin[GROUP_BIT];
                    controlFormat  = 1'b1;
                    portReadStrobe = 1'b1;
                    ackMask        = portSelect;
                    bRegData       = portReadData[asrWin[IDX_W-1:0]];
                    bRegData[WORD_W-1:POS_LSB] = asrWin[IDX_W-1:0];
                    bRegValid      = 1'b1;
                end
            end
            default:
            begin
                bRegValid = 1'b0;
            end
        endcase
    end

    // Selection, pending interrupts and direction
    always_comb
    begin
        s_d = s_q;
        if (cmd.cmdTwo)
        begin
            s_d.selTwo = 1'b1;
        end
        else if (cmd.cmdOne)
        begin
            s_d.selTwo = 1'b0;
        end
        // A new interrupt in the acknowledge cycle is kept
        s_d.stPend = (s_q.stPend & ~ackMask) | portIrq.status;
        s_d.dtPend = (s_q.dtPend & ~ackMask) | portIrq.data;
        if (op == OP_WRITE)
        begin
            s_d.dirOut = 1'b1;
        end
        else if (op == OP_READ)
        begin
            s_d.dirOut = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '{selTwo: SEL_RESET, stPend: '0, dtPend: '0, dirOut: DIR_RESET};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign portDirOut       = s_q.dirOut;
    assign statusAck        = ackMask;
    assign statusLines      = unaddrWin[IDX_W-1:0];
    assign statusLinesValid = unaddrWin[IDX_W];

    // Control unit requests
    always_comb
    begin
        cuReq.unaddressed = unaddrWin[IDX_W];
        cuReq.position    = unaddrWin[IDX_W-1:0];
        cuReq.unsolicited = s_q.stPend[idx];
        cuReq.solicited   = s_q.dtPend[idx];
    end

    loader_path u_loader_path
    (
        .clk         (clk),
        .rst         (rst),
        .loadSwitch  (loadSwitch),
        .loaderValid (loaderValid),
        .loaderWord  (loaderWord),
        .mpmWrite    (mpmWrite),
        .mpmAddr     (mpmAddr),
        .mpmData     (mpmData)
    );

    chk_prio_top:
    assert property (@(posedge clk) disable iff (rst)
        pend[PORT_CNT-1] && idx != IDX_W'(PORT_CNT-1)
        |-> cuReq.unaddressed && cuReq.position == IDX_W'(PORT_CNT-1))
    else $error("position 8 did not win priority");

    chk_irq_raises:
    assert property (@(posedge clk) disable iff (rst)
        (portIrq.status | portIrq.data) != '0
        |=> cuReq.unaddressed || cuReq.unsolicited || cuReq.solicited)
    else $error("interrupt did not raise a request");

    chk_asr_answer:
    assert property (@(posedge clk) disable iff (rst)
        cmd.statusReq && pend != '0
        |-> bRegValid && controlFormat && bRegData[WORD_W-1:POS_LSB] == asrWin[IDX_W-1:0])
    else $error("status answer lacks position");

    chk_req_hold:
    assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (($past(s_q.stPend & ~ackMask) & ~s_q.stPend) == '0))
    else $error("status request dropped before acknowledge");

    chk_mem_excl:
    assert property (@(posedge clk) disable iff (rst)
        cmd.memOp && !cmd.statusReq |-> !portReadStrobe && !portWriteStrobe)
    else $error("device access during memory operation");

    chk_b_idle:
    assert property (@(posedge clk) disable iff (rst)
        !bRegValid |-> bRegData == '0)
    else $error("B register path driven while idle");

    chk_base_sel:
    assert property (@(posedge clk) disable iff (rst)
        cmd.cmdOne && !cmd.cmdTwo ##1 !cmd.cmdOne && !cmd.cmdTwo |-> devAddr == baseRegOne)
    else $error("base register selection not kept");

    chk_write_path:
    assert property (@(posedge clk) disable iff (rst)
        portWriteStrobe |-> portWriteData == processorWriteBus && $onehot(portSelect))
    else $error("write data not from processor bus");

    chk_dir_set:
    assert property (@(posedge clk) disable iff (rst)
        portWriteStrobe |=> portDirOut)
    else $error("direction not set to output after write");

    chk_dir_in:
    assert property (@(posedge clk) disable iff (rst)
        portReadStrobe && !cmd.statusReq |=> !portDirOut)
    else $error("direction not set to input after read");

    chk_prio_rank:
    assert property (@(posedge clk) disable iff (rst)
        cuReq.unaddressed |-> ((pend & ~idxMask) >> cuReq.position) == port_mask_t'(1))
    else $error("lower position won unaddressed priority");

    chk_unaddr_only:
    assert property (@(posedge clk) disable iff (rst)
        cuReq.unaddressed |-> cuReq.position != idx && pend[cuReq.position])
    else $error("unaddressed request names the addressed port");

    chk_no_unaddr:
    assert property (@(posedge clk) disable iff (rst)
        (pend & ~idxMask) == '0 |-> !cuReq.unaddressed)
    else $error("unaddressed request without a pending port");

    chk_lines_match:
    assert property (@(posedge clk) disable iff (rst)
        statusLinesValid == cuReq.unaddressed && statusLines == cuReq.position)
    else $error("status lines disagree with the winning port");

    chk_unsol_set:
    assert property (@(posedge clk) disable iff (rst)
        portIrq.status[idx] ##1 $stable(idx) |-> cuReq.unsolicited)
    else $error("addressed status interrupt not unsolicited");

    chk_sol_set:
    assert property (@(posedge clk) disable iff (rst)
        portIrq.data[idx] ##1 $stable(idx) |-> cuReq.solicited)
    else $error("addressed data interrupt not solicited");

    chk_read_path:
    assert property (@(posedge clk) disable iff (rst)
        portReadStrobe && !cmd.statusReq |-> bRegValid && bRegData == portReadData[idx])
    else $error("read data not routed to B register");

    chk_ack_single:
    assert property (@(posedge clk) disable iff (rst)
        cmd.statusReq && pend != '0
        |-> $onehot(statusAck) && statusAck == portSelect && portReadStrobe)
    else $error("status request did not address one port");

    chk_group_sel:
    assert property (@(posedge clk) disable iff (rst)
        portSelect != '0
        |-> $onehot(groupSelect) && groupSelect[1] == (portSelect[PORT_CNT-1:PORT_CNT/2] != '0))
    else $error("group select does not match the port");
endmodule : port_selector

// ---- design/port_select_pkg.sv ----
package port_select_pkg;
    localparam int WORD_W     = 16;
    localparam int PORT_CNT   = 8;
    localparam int GROUP_CNT  = 2;
    localparam int IDX_W      = 3;
    localparam int FORMAT_BIT = 15;
    localparam int GROUP_BIT  = 2;
    localparam int POS_LSB    = 13;
    localparam int MPM_ADDR_W = 14;
    localparam int MPM_WORD_W = 17;
    localparam int PARITY_BIT = 16;

    localparam logic [MPM_ADDR_W-1:0] MPM_START = 14'h0000;
    localparam logic                  SEL_RESET = 1'h0;
    localparam logic                  DIR_RESET = 1'h0;

    typedef logic [WORD_W-1:0]             word_t;
    typedef word_t [PORT_CNT-1:0]          port_words_t;
    typedef logic [PORT_CNT-1:0]           port_mask_t;

    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE, OP_STATUS} dev_op_t;

    typedef struct packed {
        logic read;
        logic write;
        logic cmdOne;
        logic cmdTwo;
        logic statusReq;
        logic memOp;
    } ext_cmd_t;

    typedef struct packed {
        port_mask_t status;
        port_mask_t data;
    } port_irq_t;

    typedef struct packed {
        logic             unaddressed;
        logic             unsolicited;
        logic             solicited;
        logic [IDX_W-1:0] position;
    } cu_req_t;

    function automatic logic oddParity(input word_t w);
        return ~(^w);
    endfunction : oddParity

    // Returns {valid, index}; highest index (position 8) wins
    function automatic logic [IDX_W:0] pickHighest(input port_mask_t req);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = 0; i < PORT_CNT; i++)
        begin
            if (req[i])
            begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction : pickHighest
endpackage : port_select_pkg

// ---- design/loader_path.sv ----
module loader_path
    import port_select_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  loadSwitch,
    input  wire logic                  loaderValid,
    input  wire word_t                 loaderWord,
    output logic                       mpmWrite,
    output logic [MPM_ADDR_W-1:0]      mpmAddr,
    output logic [MPM_WORD_W-1:0]      mpmData
);
    typedef struct packed {
        logic [MPM_ADDR_W-1:0] next;
        logic                  wr;
        logic [MPM_ADDR_W-1:0] addr;
        logic [MPM_WORD_W-1:0] data;
    } ld_state_t;

    ld_state_t s_q;
    ld_state_t s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.wr = 1'b0;
        if (!loadSwitch)
        begin
            s_d.next = MPM_START;
        end
        else if (loaderValid)
        begin
            s_d.wr   = 1'b1;
            s_d.addr = s_q.next;
            s_d.next = s_q.next + 1'b1;
            s_d.data[WORD_W-1:0] = loaderWord;
            s_d.data[PARITY_BIT] = oddParity(loaderWord);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '{next: MPM_START, wr: 1'b0, addr: MPM_START, data: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign mpmWrite = s_q.wr;
    assign mpmAddr  = s_q.addr;
    assign mpmData  = s_q.data;

    chk_load_word:
    assert property (@(posedge clk) disable iff (rst)
        loadSwitch && loaderValid |=> mpmWrite && mpmData[WORD_W-1:0] == $past(loaderWord))
    else $error("loader word not written next cycle");

    chk_parity_odd:
    assert property (@(posedge clk) disable iff (rst) mpmWrite |-> ^mpmData == 1'b1)
    else $error("microprogram word parity not odd");

    chk_addr_step:
    assert property (@(posedge clk) disable iff (rst)
        mpmWrite && loadSwitch && loaderValid |=> mpmAddr == $past(mpmAddr) + 1'b1)
    else $error("loader address did not ascend by one");
endmodule : loader_path

// ---- test/device_port_model.sv ----
module device_port_model
    import port_select_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire port_mask_t          raiseStatus,
    input  wire port_mask_t          raiseData,
    input  wire logic [PORT_CNT-1:0] portSelect,
    input  wire logic                controlFormat,
    input  wire logic                portWriteStrobe,
    input  wire word_t               portWriteData,
    input  wire logic [PORT_CNT-1:0] statusAck,
    output port_words_t              portReadData,
    output port_irq_t                portIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    port_mask_t stPend;
    port_mask_t dtPend;
    word_t      dataWord [PORT_CNT];
    word_t      value    [PORT_CNT];

    always @(posedge clk)
    begin
        for (int i = 0; i < PORT_CNT; i++)
        begin
            if (rst)
                dataWord[i] <= '0;
            else if (portWriteStrobe && portSelect[i])
                dataWord[i] <= portWriteData;
        end
        stPend <= rst ? '0 : (stPend | raiseStatus) & ~statusAck;
        dtPend <= rst ? '0 : (dtPend | raiseData) & ~statusAck;
    end

    // Requests stay up whether addressed or not; dropped as status is read
    assign portIrq.status = stPend & ~statusAck;
    assign portIrq.data   = dtPend & ~statusAck;

    // Unselected ports show an inverted word so stale data cannot pass
    always_comb
    begin
        for (int i = 0; i < PORT_CNT; i++)
        begin
            value[i] = controlFormat ? 16'h5a00 + 16'(i) : dataWord[i];
            portReadData[i] = portSelect[i] ? value[i] : ~value[i];
        end
    end
endmodule : device_port_model

// ---- test/port_select_io_interrupt_unit_tb.sv ----
module port_select_io_interrupt_unit_tb
    import port_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk;
    logic                  rst;
    ext_cmd_t              cmd;
    word_t                 baseRegOne;
    word_t                 baseRegTwo;
    word_t                 processorWriteBus;
    word_t                 loaderWord;
    port_words_t           portReadData;
    port_irq_t             portIrq;
    logic                  loadSwitch;
    logic                  loaderValid;
    port_mask_t            raiseStatus;
    port_mask_t            raiseData;
    logic [PORT_CNT-1:0]   portSelect;
    logic [PORT_CNT-1:0]   statusAck;
    logic [GROUP_CNT-1:0]  groupSelect;
    logic                  controlFormat;
    logic                  portWriteStrobe;
    logic                  portReadStrobe;
    logic                  portDirOut;
    logic                  bRegValid;
    logic                  statusLinesValid;
    logic                  mpmWrite;
    word_t                 portWriteData;
    word_t                 bRegData;
    logic [IDX_W-1:0]      statusLines;
    cu_req_t               cuReq;
    logic [MPM_ADDR_W-1:0] mpmAddr;
    logic [MPM_WORD_W-1:0] mpmData;
    int                    nErrors;
    int                    samplesChecked;

    port_selector u_port_selector (.clk(clk), .rst(rst), .cmd(cmd), .baseRegOne(baseRegOne),
        .baseRegTwo(baseRegTwo), .processorWriteBus(processorWriteBus),
        .portReadData(portReadData), .portIrq(portIrq), .loadSwitch(loadSwitch),
        .loaderValid(loaderValid), .loaderWord(loaderWord), .portSelect(portSelect),
        .groupSelect(groupSelect), .controlFormat(controlFormat),
        .portWriteData(portWriteData), .portWriteStrobe(portWriteStrobe),
        .portReadStrobe(portReadStrobe), .portDirOut(portDirOut), .statusAck(statusAck),
        .bRegData(bRegData), .bRegValid(bRegValid), .statusLines(statusLines),
        .statusLinesValid(statusLinesValid), .cuReq(cuReq), .mpmWrite(mpmWrite),
        .mpmAddr(mpmAddr), .mpmData(mpmData));

    device_port_model u_device_port_model (.clk(clk), .rst(rst), .raiseStatus(raiseStatus),
        .raiseData(raiseData), .portSelect(portSelect), .controlFormat(controlFormat),
        .portWriteStrobe(portWriteStrobe), .portWriteData(portWriteData),
        .statusAck(statusAck), .portReadData(portReadData), .portIrq(portIrq));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : reportAndStop

    task automatic chkBit(input logic got, input logic exp, input string what);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask : chkBit

    task automatic chkVec(input logic [16:0] got, input logic [16:0] exp, input string what);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chkVec

    task automatic tick();
        @(posedge clk);
        @(negedge clk);
    endtask : tick

    // Drives one command, held until the next assignment, and settles 1 ns; checks happen before the sampling edge
    task automatic issue(input logic r, input logic w, input logic one, input logic two,
                         input logic sr, input logic mem);
        cmd = '{r, w, one, two, sr, mem};
        #1;
    endtask : issue

    task automatic testWrite();
        for (int p = 0; p < PORT_CNT; p++)
        begin
            baseRegTwo = 16'(p);
            baseRegOne = 16'(7 - p);
            processorWriteBus = 16'h1000 + 16'(p);
            issue(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
            chkVec(17'(portSelect), 17'(8'h01 << p), "select");
            chkVec(17'(groupSelect), (p > 3) ? 17'h2 : 17'h1, "group");
            chkBit(portWriteStrobe, 1'b1, "wr strobe");
            chkVec(17'(portWriteData), 17'(processorWriteBus), "wr data");
            tick();
            chkBit(portDirOut, 1'b1, "dir out");
        end
        issue(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chkVec(17'(portSelect), 17'h80, "keep two");
        tick();
        issue(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chkVec(17'(portSelect), 17'h01, "pick one");
        tick();
        issue(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chkVec(17'(portSelect), 17'h01, "keep one");
        tick();
        issue(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        chkVec(17'(portSelect), 17'h80, "two wins");
        tick();
        cmd = '0;
        #1;
        chkBit(portWriteStrobe, 1'b0, "idle strobe");
        chkVec(17'(portWriteData), 17'h0, "idle wr data");
        $display("test write done");
    endtask : testWrite

    task automatic testRead();
        baseRegOne = 16'h0002;
        processorWriteBus = 16'hbeef;
        issue(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        tick();
        issue(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chkBit(controlFormat, 1'b0, "data fmt");
        chkBit(portReadStrobe, 1'b1, "rd strobe");
        chkBit(bRegValid, 1'b1, "b valid");
        chkVec(17'(bRegData), 17'hbeef, "rd data");
        tick();
        chkBit(portDirOut, 1'b0, "dir in");
        baseRegOne = 16'h8002;
        issue(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chkBit(controlFormat, 1'b1, "ctl fmt");
        chkVec(17'(bRegData), 17'h5a02, "status rd");
        tick();
        issue(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        chkBit(portReadStrobe | portWriteStrobe, 1'b0, "mem blocks");
        chkBit(bRegValid, 1'b0, "mem no b");
        tick();
        cmd = '0;
        #1;
        chkBit(bRegValid, 1'b0, "idle b");
        chkVec(17'(bRegData), 17'h0, "idle b data");
        $display("test read done");
    endtask : testRead

    // Firmware services the highest pending port through a status request
    task automatic serve(input int p);
        issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        chkVec(17'(statusAck), 17'(8'h01 << p), "ack");
        chkVec(17'(portSelect), 17'(8'h01 << p), "sr select");
        chkBit(bRegValid, 1'b1, "sr valid");
        chkVec(17'(bRegData), 17'({3'(p), 13'h1a00 + 13'(p)}), "reason");
        tick();
    endtask : serve

    task automatic testIrq();
        baseRegOne = 16'h0000;
        raiseStatus = 8'hff;
        tick();
        raiseStatus = '0;
        repeat (3) tick();
        for (int p = 7; p >= 1; p--)
        begin
            chkBit(cuReq.unaddressed, 1'b1, "unaddr");
            chkVec(17'(cuReq.position), 17'(p), "position");
            chkVec(17'(statusLines), 17'(p), "status lines");
            chkBit(statusLinesValid, 1'b1, "lines valid");
            serve(p);
        end
        chkBit(cuReq.unaddressed, 1'b0, "only addr");
        chkBit(cuReq.unsolicited, 1'b1, "unsol");
        chkBit(cuReq.solicited, 1'b0, "no sol");
        serve(0);
        chkBit(cuReq.unsolicited, 1'b0, "unsol clr");
        cmd = '0;
        raiseData = 8'h09;
        tick();
        raiseData = '0;
        repeat (3) tick();
        chkBit(cuReq.solicited, 1'b1, "sol");
        chkBit(cuReq.unaddressed, 1'b1, "data unaddr");
        chkVec(17'(cuReq.position), 17'h3, "data pos");
        serve(3);
        serve(0);
        chkBit(cuReq.solicited | cuReq.unaddressed, 1'b0, "all clr");
        chkBit(statusLinesValid, 1'b0, "lines clr");
        issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        chkBit(bRegValid, 1'b0, "none pending");
        tick();
        cmd = '0;
        $display("test irq done");
    endtask : testIrq

    task automatic testLoader();
        word_t w [4] = '{16'h0000, 16'h0001, 16'hffff, 16'h8003};
        loadSwitch = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            loaderValid = 1'b1;
            loaderWord = w[k];
            tick();
            chkBit(mpmWrite, 1'b1, "mpm write");
            chkVec(17'(mpmAddr), 17'(k), "mpm addr");
            chkVec(mpmData, {~^w[k], w[k]}, "mpm data");
        end
        loaderValid = 1'b0;
        tick();
        chkBit(mpmWrite, 1'b0, "one per word");
        loadSwitch = 1'b0;
        loaderValid = 1'b1;
        tick();
        chkBit(mpmWrite, 1'b0, "switch off");
        loadSwitch = 1'b1;
        tick();
        loaderValid = 1'b0;
        chkVec(17'(mpmAddr), 17'h0, "restart");
        $display("test loader done");
    endtask : testLoader

    initial
    begin
        nErrors = 0;
        samplesChecked = 0;
        rst = 1'b1;
        cmd = '0;
        baseRegOne = '0;
        baseRegTwo = '0;
        processorWriteBus = '0;
        loaderWord = '0;
        loadSwitch = 1'b0;
        loaderValid = 1'b0;
        raiseStatus = '0;
        raiseData = '0;
        repeat (6) tick();
        chkBit(mpmWrite | portDirOut | portWriteStrobe, 1'b0, "reset outs");
        chkBit(cuReq.unaddressed, 1'b0, "reset req");
        rst = 1'b0;
        testWrite();
        testRead();
        testIrq();
        testLoader();
        reportAndStop();
    end

    initial
    begin
        #(2000 * 50);
        nErrors++;
        $display("BAD %0t watchdog expired", $time);
        reportAndStop();
    end
endmodule : port_select_io_interrupt_unit_tb
